// *** shared/isg_pkg.sv ***
// Purpose: shared constants and types for the isolated switch output gating block
// Assumes: one clock, core_clk at 250 MHz; synchronous active-low reset nrst
// Notes: all pin-side status arrives as plain levels from the analog front end
package isg_pkg;

  localparam int ISG_NUM_CH = 4;
  localparam int ISG_SYNC_STAGES = 2;

  // reset values: outputs off, indicators released
  localparam logic ISG_RST_OUTPUT = 1'h0;
  localparam logic ISG_RST_IND_OE = 1'h0;
  localparam logic ISG_IND_DRIVE_LEVEL = 1'h0;

  // fault indicator mapping, written by the host through its configuration
  typedef enum logic [1:0] {
    ISG_FMAP_FAULT_STATE = 2'h0,
    ISG_FMAP_FAULT_OR_CONSTRAINT = 2'h1,
    ISG_FMAP_NEVER = 2'h2,
    ISG_FMAP_ALWAYS = 2'h3
  } isg_fault_map_t;

  // supply status, high means powered
  typedef struct packed {
    logic logic_supply;
    logic switch_supply;
  } isg_supply_t;

  // fault conditions from the protection circuits
  typedef struct packed {
    logic over_temp_shutdown;
    logic comm_error_shutdown;
    logic other_shutdown;
    logic over_temp_constraint;
    logic over_voltage_constraint;
  } isg_fault_cond_t;

  localparam int ISG_PIN_W = $bits(isg_supply_t) + $bits(isg_fault_cond_t) + 1;

endpackage : isg_pkg

// *** design/isg_sync.sv ***
// Purpose: two-flop level synchroniser for asynchronous pin inputs
// Assumes: inputs are quasi-static levels
// Notes: first stage feeds the second stage only
module isg_sync #(
  parameter int WIDTH = 1
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta;

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      meta <= '0;
      sync_out <= '0;
    end else begin
      meta <= async_in;
      sync_out <= meta;
    end
  end

endmodule : isg_sync

// *** design/isg_output_gating.sv ***
// Purpose: output gating and fault indication for a four-channel isolated switch
// Assumes: pins and supply monitors are asynchronous and synchronised here
// Notes: all outputs are registered; the fault state clears on its own
module isg_output_gating
  import isg_pkg::*;
#(
  parameter int NUM_CH = ISG_NUM_CH
) (
  input wire logic core_clk,
  input wire logic nrst,
  // variant select: high takes commands from the register, low from the pins
  input wire logic register_mode,
  input wire logic [NUM_CH-1:0] channel_switch_command_reg,
  input wire logic [NUM_CH-1:0] channel_command_pin,
  input wire logic output_enable_pin,
  input wire isg_supply_t supply_status,
  input wire isg_fault_cond_t fault_cond,
  input wire isg_fault_map_t fault_map,
  output logic [NUM_CH-1:0] channel_output,
  output logic fault_state,
  output logic fault_indicator_n_o,
  output logic fault_indicator_n_oe,
  input wire logic fault_indicator_n_i,
  output logic fault_line_low,
  output logic [NUM_CH-1:0] channel_status_indicator_n_o,
  output logic [NUM_CH-1:0] channel_status_indicator_n_oe
);

  // pin-side levels, synchronised before use
  logic [NUM_CH-1:0] cmd_pin_s;
  logic [ISG_PIN_W-1:0] misc_s;
  logic fault_pin_s;
  logic oe_s;
  isg_supply_t sup_s;
  isg_fault_cond_t flt_s;

  isg_sync #(
    .WIDTH(NUM_CH)
  ) u_sync_cmd (
    .core_clk(core_clk),
    .nrst(nrst),
    .async_in(channel_command_pin),
    .sync_out(cmd_pin_s)
  );

  isg_sync #(
    .WIDTH(ISG_PIN_W)
  ) u_sync_misc (
    .core_clk(core_clk),
    .nrst(nrst),
    .async_in({output_enable_pin, supply_status, fault_cond}),
    .sync_out(misc_s)
  );

  // the wired fault line is read back so a host-side fault on a shared line is visible
  isg_sync #(
    .WIDTH(1)
  ) u_sync_fault_line (
    .core_clk(core_clk),
    .nrst(nrst),
    .async_in(fault_indicator_n_i),
    .sync_out(fault_pin_s)
  );

  always_comb begin
    oe_s = misc_s[ISG_PIN_W-1];
    sup_s = misc_s[ISG_PIN_W-2 -: $bits(isg_supply_t)];
    flt_s = misc_s[$bits(isg_fault_cond_t)-1:0];
  end

  // command source; register bits come from same-clock logic, no synchroniser
  logic [NUM_CH-1:0] cmd_sel;

  always_comb begin
    if (register_mode) begin
      cmd_sel = channel_switch_command_reg;
    end else begin
      cmd_sel = cmd_pin_s;
    end
  end

  // fault state: registered each cycle from present causes only, so no clear is needed
  logic next_fault_state;

  always_comb begin
    next_fault_state = !sup_s.switch_supply
                       || flt_s.over_temp_shutdown
                       || flt_s.comm_error_shutdown
                       || flt_s.other_shutdown;
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      fault_state <= 1'h0;
    end else begin
      fault_state <= next_fault_state;
    end
  end

  // per-channel gating; the overvoltage constraint is deliberately not looked at
  logic [NUM_CH-1:0] next_channel_output;

  genvar ch;
  generate
    for (ch = 0; ch < NUM_CH; ch++) begin : g_ch
      logic gate;

      always_comb begin
        gate = sup_s.logic_supply && !next_fault_state
               && cmd_sel[ch] && oe_s;
        // the over-temperature constraint holds an on channel on but stops an off one turning on
        next_channel_output[ch] = gate
                                  && (channel_output[ch]
                                      || !flt_s.over_temp_constraint);
      end

      always_ff @(posedge core_clk) begin
        if (!nrst) begin
          channel_output[ch] <= ISG_RST_OUTPUT;
          channel_status_indicator_n_oe[ch] <= ISG_RST_IND_OE;
          channel_status_indicator_n_o[ch] <= ISG_IND_DRIVE_LEVEL;
        end else begin
          channel_output[ch] <= next_channel_output[ch];
          // status follows the output: on pulls the pin low
          channel_status_indicator_n_oe[ch] <= next_channel_output[ch];
          channel_status_indicator_n_o[ch] <= ISG_IND_DRIVE_LEVEL;
        end
      end
    end
  endgenerate

  // fault indicator mapping; an unpowered logic side releases the pin,
  // which is one legal value of the undefined level
  logic next_fault_ind;

  always_comb begin
    case (fault_map)
      ISG_FMAP_FAULT_STATE: begin
        next_fault_ind = next_fault_state;
      end
      ISG_FMAP_FAULT_OR_CONSTRAINT: begin
        next_fault_ind = next_fault_state
                         || flt_s.over_temp_constraint
                         || flt_s.over_voltage_constraint;
      end
      ISG_FMAP_NEVER: begin
        next_fault_ind = 1'h0;
      end
      ISG_FMAP_ALWAYS: begin
        next_fault_ind = 1'h1;
      end
      default: begin
        next_fault_ind = next_fault_state;
      end
    endcase
    if (!sup_s.logic_supply) begin
      next_fault_ind = 1'h0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      fault_indicator_n_oe <= ISG_RST_IND_OE;
      fault_indicator_n_o <= ISG_IND_DRIVE_LEVEL;
    end else begin
      fault_indicator_n_oe <= next_fault_ind;
      fault_indicator_n_o <= ISG_IND_DRIVE_LEVEL;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      fault_line_low <= 1'h0;
    end else begin
      fault_line_low <= !fault_pin_s;
    end
  end

endmodule : isg_output_gating

// *** verification/isg_output_gating_properties.sv ***
// Purpose: port checks for isg_output_gating
// Assumes: pin inputs reach outputs within four edges
// Notes: windows run one edge past the sync delay
module isg_checker
  import isg_pkg::*;
#(
  parameter int NUM_CH = ISG_NUM_CH
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic register_mode,
  input wire logic [NUM_CH-1:0] channel_switch_command_reg,
  input wire isg_supply_t supply_status,
  input wire isg_fault_cond_t fault_cond,
  input wire isg_fault_map_t fault_map,
  input wire logic [NUM_CH-1:0] channel_output,
  input wire logic fault_state,
  input wire logic fault_indicator_n_o,
  input wire logic fault_indicator_n_oe,
  input wire logic [NUM_CH-1:0] channel_status_indicator_n_o,
  input wire logic [NUM_CH-1:0] channel_status_indicator_n_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  sequence s_sw_lost; !supply_status.switch_supply [*4]; endsequence
  sequence s_clear; (supply_status.switch_supply && fault_cond[4:2] == 3'h0) [*5]; endsequence
  property p_mirror; channel_status_indicator_n_oe == channel_output; endproperty
  a_mirror: assert property (p_mirror) else $error("status differs");
  property p_low; !fault_indicator_n_o && channel_status_indicator_n_o == '0; endproperty
  a_low: assert property (p_low) else $error("drive level high");
  property p_sw_lost; s_sw_lost |=> fault_state; endproperty
  a_sw_lost: assert property (p_sw_lost) else $error("no fault");
  property p_clear; s_clear |=> !fault_state; endproperty
  a_clear: assert property (p_clear) else $error("fault stuck");
  property p_fault_off; fault_state |-> channel_output == '0; endproperty
  a_fault_off: assert property (p_fault_off) else $error("on in fault");
  property p_reg; $past(register_mode) |->
    (channel_output & ~$past(channel_output) & ~$past(channel_switch_command_reg)) == '0;
  endproperty
  a_reg: assert property (p_reg) else $error("on without command");
  property p_otc; fault_cond.over_temp_constraint [*5] |->
    (channel_output & ~$past(channel_output)) == '0;
  endproperty
  a_otc: assert property (p_otc) else $error("on under constraint");
  property p_never; $past(fault_map) == ISG_FMAP_NEVER |-> !fault_indicator_n_oe; endproperty
  a_never: assert property (p_never) else $error("indicator pulled");
endmodule : isg_checker

// *** verification/isg_host_model.sv ***
// Purpose: host pins and the pulled-up fault line
// Assumes: host always drives defined levels
// Notes: a released fault line reads high through its pull-up
module isg_host_model (
  input wire logic [3:0] cmd,
  input wire logic en,
  input wire logic fault_indicator_n_o,
  input wire logic fault_indicator_n_oe,
  output logic [3:0] channel_command_pin,
  output logic output_enable_pin,
  output logic fault_indicator_n_i
);
  timeunit 1ns;
  timeprecision 1ps;
  assign channel_command_pin = cmd;
  assign output_enable_pin = en;
  assign fault_indicator_n_i = fault_indicator_n_oe ? fault_indicator_n_o : 1'h1;
endmodule : isg_host_model

// *** verification/tb.sv ***
// Purpose: self-checking bench for isg_output_gating
// Assumes: core_clk 4 ns, reset held 6 cycles
// Notes: pins need three edges, so checks wait four
module tb import isg_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'h0;
  logic nrst = 1'h0;
  logic register_mode = 1'h1;
  logic [3:0] channel_switch_command_reg = 4'h0;
  logic [3:0] cmd = 4'h0;
  logic en = 1'h1;
  isg_supply_t supply_status = 2'h3;
  isg_fault_cond_t fault_cond = 5'h00;
  isg_fault_map_t fault_map = ISG_FMAP_FAULT_STATE;
  logic [3:0] channel_command_pin, channel_output, channel_status_indicator_n_o;
  logic [3:0] channel_status_indicator_n_oe;
  logic output_enable_pin, fault_state, fault_indicator_n_o, fault_indicator_n_oe;
  logic fault_indicator_n_i, fault_line_low;
  logic [31:0] seed = 32'h94cc6c6c;
  int error_cnt = 0;
  int n_tests = 0;
  always #2 core_clk = ~core_clk;
  isg_host_model i_host (.*);
  isg_output_gating i_dut (.*);
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    return s ^ (s << 5);
  endfunction : xs
  task automatic chk(input logic [3:0] got, input logic [3:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : step
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : give_verdict
  initial begin
    step(6);
    nrst = 1'h1;
    for (int i = 0; i < 24; i++) begin
      seed = xs(seed);
      register_mode = i < 4 | seed[8];
      channel_switch_command_reg = i < 4 ? 4'h1 << i : seed[3:0];
      cmd = seed[7:4];
      en = i < 4 | seed[9];
      step(4);
      chk(channel_output, (register_mode ? channel_switch_command_reg : cmd) & {4{en}});
      chk(channel_status_indicator_n_oe, (register_mode ? channel_switch_command_reg : cmd) & {4{en}});
    end
    $display("gating done");
    register_mode = 1'h1;
    channel_switch_command_reg = 4'h5;
    en = 1'h1;
    supply_status.switch_supply = 1'h0;
    // line_low trails the pin by three more edges
    step(8);
    chk({fault_state, fault_indicator_n_oe, fault_line_low, 1'h0}, 4'he);
    chk({fault_indicator_n_i, fault_indicator_n_o, channel_output[1:0]}, 4'h0);
    supply_status.switch_supply = 1'h1;
    step(8);
    chk({fault_state, fault_indicator_n_oe, fault_line_low, 1'h0}, 4'h0);
    chk(channel_output, 4'h5);
    fault_cond.over_temp_constraint = 1'h1;
    step(4);
    chk(channel_output, 4'h5);
    channel_switch_command_reg = 4'hf;
    step(4);
    chk(channel_output, 4'h5);
    fault_cond = 5'h01;
    step(4);
    chk(channel_output, 4'hf);
    $display("fault done");
    for (int m = 0; m < 4; m++) begin
      fault_map = isg_fault_map_t'(m);
      step(2);
      chk({3'h0, fault_indicator_n_oe}, {3'h0, m[0]});
    end
    supply_status.logic_supply = 1'h0;
    step(4);
    chk({fault_indicator_n_oe, channel_output[2:0]}, 4'h0);
    $display("map and supply done");
    give_verdict();
  end
  initial begin
    #5000;
    error_cnt++;
    give_verdict();
  end
endmodule : tb
bind isg_output_gating isg_checker #(.NUM_CH(NUM_CH)) i_chk (.*);
